// ==== include/btcd_defs.svh ====
/*
 Opcode fields and reset constants for the bit test, toggle and call decoder.
 Assumes the includer wants plain macros; no logic here.
*/
`ifndef BTCD_DEFS_SVH
`define BTCD_DEFS_SVH
`define BTCD_OP_SKIPSET   8'h90
`define BTCD_OP_SKIPMASK  8'hF8
`define BTCD_OP_TOGGLE    8'h38
`define BTCD_OP_TGLMASK   8'hF8
`define BTCD_OP_CALL      3'h7
`define BTCD_LIT_W        13
`define BTCD_PC_RST       16'h0000
`define BTCD_LATCH_RST    8'h00
`endif

// ==== include/btcd_pkg.sv ====
/*
 Types shared by the decoder: Q phases, instruction class and memory request.
 Assumes btcd_defs.svh is on the include path.
*/
package btcd_pkg;
   typedef enum logic [1:0] {PhQ1, PhQ2, PhQ3, PhQ4} btcd_phase_e;
   typedef enum logic [1:0] {InsOther, InsSkipSet, InsToggle, InsCall} btcd_class_e;
   typedef struct packed {
      logic       rdEn;
      logic       wrEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } btcd_mem_s;
endpackage : btcd_pkg

// ==== hdl/btcd_phase_gen.sv ====
/*
 Four-phase generator that splits each instruction cycle into Q1..Q4.
 Assumes a single clock; one phase per clock edge.
*/
`timescale 1ns/1ns
module btcd_phase_gen
   import btcd_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   output btcd_phase_e      phase
);
   btcd_phase_e phase_q;

   // Phases advance every clock so a cycle spans four edges.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         phase_q <= PhQ1;
      end else begin
         phase_q <= btcd_phase_e'(phase_q + 2'h1);
      end
   end

   assign phase = phase_q;
endmodule : btcd_phase_gen

// ==== hdl/btcd_core.sv ====
/*
 Decode and execute of bit test skip if set, bit invert and short call.
 Assumes the fetch unit presents the opcode stably across a cycle and data
 memory returns read data by Q3 of the cycle whose Q2 requested it.
*/
// Functional notes
// - Skip-if-set reads bit b of f, skips next when one, no flags.
// - On skip the fetched instruction is dropped; a forced nop cycle follows.
// - Bit invert reads f in Q2, writes inverted bit in Q4, no flags.
// - Short call carries a 13-bit literal targeting the current 8K page.
// - Short call pushes address of following instruction as top of stack.
// - Short call loads literal into counter bits 12..0, keeps 15..13.
// - High latch gets literal 12..8 low and counter 15..13 high.
// - Short call takes two cycles; second is forced nop, no flags.
`timescale 1ns/1ns
`include "btcd_defs.svh"
module btcd_core
   import btcd_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] opcode,
   input  wire logic [7:0]  memRdData,
   output btcd_mem_s        memReq,
   output logic [15:0]      progCounter,
   output logic [15:0]      topOfReturnStack,
   output logic             stackPush,
   output logic [7:0]       programCounterHighLatch,
   output logic             flushFetch,
   output logic             forcedNop
);
   btcd_phase_e phase;
   btcd_class_e insClass_q;
   btcd_mem_s   memReq_q;
   logic [15:0] pc_q;
   logic [15:0] tos_q;
   logic        push_q;
   logic [7:0]  latch_q;
   logic        flush_q;
   logic        nop_q;
   logic [7:0]  rdData_q;

   btcd_phase_gen u_phase (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .phase   (phase)
   );

   // Opcode classification, decoded in Q1 of a normal cycle.
   function automatic btcd_class_e classify(input logic [15:0] op);
      if ((op[15:8] & `BTCD_OP_SKIPMASK) == `BTCD_OP_SKIPSET) begin
         return InsSkipSet;
      end else if ((op[15:8] & `BTCD_OP_TGLMASK) == `BTCD_OP_TOGGLE) begin
         return InsToggle;
      end else if (op[15:13] == `BTCD_OP_CALL) begin
         return InsCall;
      end else begin
         return InsOther;
      end
   endfunction : classify

   wire btcd_class_e decoded   = classify(opcode);
   wire logic [2:0]  bitSel    = opcode[10:8];
   wire logic [7:0]  fileAddr  = opcode[7:0];
   wire logic [12:0] callLit   = opcode[12:0];
   wire logic [7:0]  bitMask   = 8'h01 << bitSel;
   wire logic        testedBit = |(rdData_q & bitMask);
   wire logic [15:0] pcNext    = pc_q + 16'h0001;
   wire logic [15:0] callPc    = {pc_q[15:13], callLit};
   wire logic [7:0]  callLatch = {pc_q[15:13], callLit[12:8]};
   wire logic        inNop     = nop_q;

   // Q1 decode; a forced nop cycle decodes nothing and runs no operand read.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         insClass_q <= InsOther;
      end else if (phase == PhQ1) begin
         insClass_q <= inNop ? InsOther : decoded;
      end
   end

   // Q2 operand read request; Q4 write back for bit invert only.
   // Write data comes from the operand held since Q2, so memory may drop it after Q2.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         memReq_q <= '0;
      end else begin
         memReq_q.rdEn <= (phase == PhQ1) && !inNop
                          && (decoded == InsSkipSet || decoded == InsToggle);
         memReq_q.wrEn <= (phase == PhQ3) && (insClass_q == InsToggle);
         memReq_q.addr <= fileAddr;
         memReq_q.wrData <= rdData_q ^ bitMask;
      end
   end

   // Operand captured at the end of Q2 for test and invert.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdData_q <= 8'h00;
      end else if (phase == PhQ2) begin
         rdData_q <= memRdData;
      end
   end

   // Q4 end of cycle: counter, stack, latch and forced nop scheduling.
   // A forced nop leaves the counter alone, since the skip or call already moved it.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pc_q    <= `BTCD_PC_RST;
         tos_q   <= 16'h0000;
         push_q  <= 1'b0;
         latch_q <= `BTCD_LATCH_RST;
         flush_q <= 1'b0;
         nop_q   <= 1'b0;
      end else begin
         push_q  <= 1'b0;
         flush_q <= 1'b0;
         if (phase == PhQ4) begin
            nop_q <= 1'b0;
            if (insClass_q == InsCall) begin
               tos_q   <= pcNext;
               push_q  <= 1'b1;
               pc_q    <= callPc;
               latch_q <= callLatch;
               flush_q <= 1'b1;
               nop_q   <= 1'b1;
            end else if (insClass_q == InsSkipSet && testedBit) begin
               pc_q    <= pcNext + 16'h0001;
               flush_q <= 1'b1;
               nop_q   <= 1'b1;
            end else if (!nop_q) begin
               pc_q <= pcNext;
            end
         end
      end
   end

   // Every output is a flip-flop; flags are never touched by these opcodes.
   assign memReq                  = memReq_q;
   assign progCounter             = pc_q;
   assign topOfReturnStack        = tos_q;
   assign stackPush               = push_q;
   assign programCounterHighLatch = latch_q;
   assign flushFetch              = flush_q;
   assign forcedNop               = nop_q;

   // A call must push, flush and enter a forced nop in the same edge.
   sequence callEnd;
      phase == PhQ4 && insClass_q == InsCall;
   endsequence

   a_call_push_nop: assert property (@(posedge ref_clk) disable iff (!rst_n)
      callEnd |=> stackPush && forcedNop && flushFetch)
      else $error("call did not push and force a nop");

   a_call_tos_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
      callEnd |=> topOfReturnStack == $past(pc_q) + 16'h0001)
      else $error("return address is not call address plus one");

   a_call_pc_page: assert property (@(posedge ref_clk) disable iff (!rst_n)
      callEnd |=> progCounter == {$past(pc_q[15:13]), $past(opcode[12:0])})
      else $error("call target outside current page");

   a_call_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
      callEnd |=> programCounterHighLatch == progCounter[15:8])
      else $error("high latch does not match counter upper byte");

   a_skip_taken: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (phase == PhQ4 && insClass_q == InsSkipSet && testedBit)
      |=> forcedNop && progCounter == $past(pc_q) + 16'h0002)
      else $error("set bit did not cause a skip");

   a_skip_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (phase == PhQ4 && insClass_q == InsSkipSet && !testedBit)
      |=> !forcedNop && progCounter == $past(pc_q) + 16'h0001)
      else $error("clear bit caused a skip");

   a_toggle_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      memReq.wrEn |-> ##0 phase == PhQ4 && insClass_q == InsToggle
      && memReq.wrData == (rdData_q ^ bitMask))
      else $error("invert write wrong phase or data");

   a_nop_no_mem: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (phase == PhQ1 && forcedNop) |=> !memReq.rdEn [*4])
      else $error("forced nop cycle touched memory");

   a_read_phase: assert property (@(posedge ref_clk) disable iff (!rst_n)
      memReq.rdEn |-> phase == PhQ2)
      else $error("operand read outside second phase");

   // Checks on the forced nop slot that follows a taken skip or a call.
   // A counter step here would lose the word after a skip or the call target.
   sequence nopEnd;
      phase == PhQ4 && forcedNop;
   endsequence

   // A forced nop spans exactly one instruction cycle, four phases long.
   sequence nopCycle;
      forcedNop [*4] ##1 !forcedNop;
   endsequence

   a_nop_pc_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      nopEnd |=> progCounter == $past(pc_q))
      else $error("counter moved during a forced nop");

   a_nop_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(forcedNop) |-> nopCycle)
      else $error("forced nop not one instruction cycle long");

   a_nop_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      forcedNop |-> !memReq.wrEn)
      else $error("forced nop cycle wrote memory");

   a_push_one_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
      stackPush |=> !stackPush)
      else $error("stack push held longer than one clock");

   a_flush_has_nop: assert property (@(posedge ref_clk) disable iff (!rst_n)
      flushFetch |-> forcedNop)
      else $error("fetch flush without a forced nop");
endmodule : btcd_core

// ==== test/bit_test_toggle_call_decode_bench.sv ====
/*
 Self-checking bench for the skip-if-set, bit invert and short call decoder.
 Assumes btcd_core starts each cycle at Q1 on the first edge after reset.
*/
`timescale 1ns/1ns
module bit_test_toggle_call_decode_bench
   import btcd_pkg::*;
;
   logic        ref_clk;
   logic        rst_n;
   logic [15:0] opcode;
   logic [7:0]  memRdData;
   btcd_mem_s   memReq;
   logic [15:0] progCounter;
   logic [15:0] topOfReturnStack;
   logic        stackPush;
   logic [7:0]  programCounterHighLatch;
   logic        flushFetch;
   logic        forcedNop;
   int          err_count;
   int          num_checks;
   int          cycles;

   btcd_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .opcode(opcode),
      .memRdData(memRdData), .memReq(memReq), .progCounter(progCounter),
      .topOfReturnStack(topOfReturnStack), .stackPush(stackPush),
      .programCounterHighLatch(programCounterHighLatch),
      .flushFetch(flushFetch), .forcedNop(forcedNop));

   // Free-running 50 ns clock.
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic test_done();
      if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Runs one cycle, entered in the time step of its decode edge and left in
   // that of the next; each phase is sampled 1 ns after the edge that opens it,
   // so a pulse one clock late is caught. nxt is driven on the Q4 edge.
   task automatic run(input logic [15:0] op, input logic [7:0] rd, input logic [15:0] nxt,
      input logic mem, input logic tog, input logic fl, input logic ps,
      input logic nop, input logic [15:0] pc);
      memRdData <= rd;
      for (int i = 1; i <= 4; i++) begin
         #1;
         chk({15'h0, memReq.rdEn}, {15'h0, i == 1 && mem});
         chk({15'h0, memReq.wrEn}, {15'h0, i == 3 && tog});
         chk({15'h0, flushFetch}, {15'h0, i == 4 && fl});
         chk({15'h0, stackPush}, {15'h0, i == 4 && ps});
         if (i == 1 && mem) chk({8'h00, memReq.addr}, {8'h00, op[7:0]});
         if (i == 3 && tog) chk({8'h00, memReq.wrData}, {8'h00, rd ^ (8'h01 << op[10:8])});
         if (i == 2) chk({15'h0, forcedNop}, {15'h0, nop});
         if (i == 4) chk(progCounter, pc);
         @(posedge ref_clk);
         if (i == 3) opcode <= nxt;
      end
   endtask : run

   // A set bit skips: the fetched word is dropped and a forced nop takes its slot.
   task automatic test_skip_taken();
      run(16'h975A, 8'h80, 16'h3C33, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 16'h0002);
      run(16'h3C33, 8'hFF, 16'h9011, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 16'h0002);
   endtask : test_skip_taken

   // A clear bit falls through with no nop cycle.
   task automatic test_skip_clear();
      run(16'h9011, 8'hFE, 16'h3C75, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 16'h0003);
   endtask : test_skip_clear

   // Bit invert on a middle bit and on bit zero.
   task automatic test_toggle();
      run(16'h3C75, 8'h75, 16'h38FF, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 16'h0004);
      run(16'h38FF, 8'h00, 16'hFABC, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 16'h0005);
   endtask : test_toggle

   // Short call: push the return address, load target and latch, then a nop.
   task automatic test_call();
      run(16'hFABC, 8'h00, 16'h9700, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 16'h1ABC);
      chk(topOfReturnStack, 16'h0006);
      chk({8'h00, programCounterHighLatch}, 16'h001A);
      run(16'h9700, 8'hFF, 16'h0000, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 16'h1ABC);
   endtask : test_call

   // Reset in mid-run clears the call state; the first edge after release is Q1.
   task automatic test_reset();
      rst_n <= 1'h0;
      opcode <= 16'h9011;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'h1;
      #1;
      chk(progCounter, 16'h0000);
      chk(topOfReturnStack, 16'h0000);
      chk({8'h00, programCounterHighLatch}, 16'h0000);
      chk({15'h0, forcedNop}, 16'h0000);
      @(posedge ref_clk);
      run(16'h9011, 8'h01, 16'h0000, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 16'h0002);
   endtask : test_reset

   // Hang guard: the sequence needs about 50 cycles.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 200) begin
         err_count++;
         test_done();
      end
   end

   // Main sequence: scenarios run back to back, each from a decode edge.
   initial begin
      rst_n <= 1'h0;
      opcode <= 16'h0000;
      memRdData <= 8'h00;
      err_count = 0;
      num_checks = 0;
      cycles = 0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'h1;
      opcode <= 16'h975A;
      @(posedge ref_clk);
      test_skip_taken();
      test_skip_clear();
      test_toggle();
      test_call();
      test_reset();
      test_done();
   end
endmodule : bit_test_toggle_call_decode_bench
